// ==== status_sel_pkg.sv ====
`default_nettype none
package status_sel_pkg;
  // clock rate and time base
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
  // keypad link error must persist this long before it is shown
  localparam int unsigned KP_ERR_MS    = 1000;
  localparam int unsigned KP_ERR_CYC   = KP_ERR_MS * CYC_PER_MS;
  localparam int unsigned KP_CNT_W     = 24;

  // register byte offsets
  localparam logic [3:0] OFS_SELECT    = 4'h0;
  localparam logic [3:0] OFS_DETECT    = 4'h4;
  localparam logic [3:0] OFS_MAXFREQ   = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'hC;

  // field positions in the select register
  localparam int unsigned COL_SEL_LSB  = 0;
  localparam int unsigned REL_SEL_LSB  = 8;
  localparam int unsigned FMODE_LSB    = 16;
  localparam int unsigned KROUTE_LSB   = 20;
  localparam int unsigned FAN_POL_BIT  = 24;
  localparam int unsigned BRAKE_EN_BIT = 25;
  // field positions in the detect and status registers
  localparam int unsigned LEVEL_LSB    = 0;
  localparam int unsigned BW_LSB       = 16;
  localparam int unsigned ST_COL_BIT   = 24;
  localparam int unsigned ST_REL_BIT   = 25;
  localparam int unsigned ST_KERR_BIT  = 26;

  // source codes
  localparam logic [4:0] SRC_FAULT     = 5'h11;
  localparam int unsigned NUM_SRC      = 20;

  // reset values, frequencies in 0.01 Hz units
  localparam logic [4:0]  RST_COL_SEL  = 5'h0C;
  localparam logic [4:0]  RST_REL_SEL  = 5'h11;
  localparam logic [2:0]  RST_FMODE    = 3'h2;
  localparam logic [1:0]  RST_KROUTE   = 2'h0;
  localparam logic [15:0] RST_LEVEL    = 16'h0BB8;
  localparam logic [15:0] RST_BW       = 16'h03E8;
  localparam logic [15:0] RST_MAXFREQ  = 16'h9C40;
  localparam logic [15:0] FREQ_LIMIT   = 16'h9C40;

  // axi responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // condition flags from the drive control core
  typedef struct packed {
    logic [15:0] cmd_freq;      // commanded frequency
    logic [15:0] out_freq;      // actual running frequency
    logic        accel;         // accelerating
    logic        decel;         // decelerating
    logic        overload_warning;
    logic        inv_overload;
    logic        motor_stall;
    logic        ov_trip;
    logic        uv_trip;
    logic        other_trip;    // any trip except undervoltage
    logic        auto_restart;  // auto restart attempt active
    logic        heatsink_overheat;
    logic        ref_lost;      // analog reference lost
    logic        comm_lost;     // rs485 command lost
    logic        run_cmd;
    logic        output_active; // output voltage present
    logic        speed_search;
    logic        wait_run;
    logic        fan_fault;
    logic        brake_signal;
    logic        keypad_link_err;
  } core_status_t;
endpackage
`default_nettype wire

// ==== status_output_selector.sv ====
// Functional notes
// (R1) source 17 follows fault relay mode
// (R2) source 0: command near output frequency
// (R3) source 1: command equals level and source 0
// (R4) source 2: running frequency near level
// (R5) source 3: level reached with decel hysteresis
// (R6) source 4 inverts source 3
// (R7) level 30, bandwidth 10, limited writes
// (R8) source 5 is overload warning
// (R9) source 8 is overvoltage trip
// (R10) source 9 is undervoltage trip
// (R11) source 10 is heatsink overheat
// (R12) source 11 is reference or command loss
// (R13) source 12: run command and output active
// (R14) source 13: stopped, no run command
// (R15) source 14: constant speed running
// (R16) source 16: waiting for run command
// (R17) source 18: fan alarm when policy zero
// (R18) source 19: brake signal when enabled
// (R19) fault mode 2: trips except undervoltage
// (R20) keypad routing bit0 collector, bit1 relay
// (R21) keypad error flagged after persistence time
// (R22) fault mode bits: uv, other, restart
// (R23) outputs registered every cycle, reset low
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module status_output_selector
  import status_sel_pkg::*;
#(
  parameter int unsigned KP_CYC = KP_ERR_CYC  // keypad persistence cycles
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire core_status_t core,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic              open_collector_out,
  output logic              relay_contact_out
);

  // configuration registers
  logic [4:0]  col_sel_r;      // collector_source_select
  logic [4:0]  rel_sel_r;      // relay_source_select
  logic [2:0]  fmode_r;        // fault_relay_mode
  logic [1:0]  kroute_r;       // keypad_error_routing
  logic        fan_pol_r;      // fan_trip_policy
  logic        brake_en_r;     // external brake use
  logic [15:0] level_r;        // freq_detect_level
  logic [15:0] bw_r;           // freq_detect_bandwidth
  logic [15:0] maxf_r;         // max_frequency
  // bus side state
  logic        aw_have_r;      // write address latched
  logic        w_have_r;       // write data latched
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  // detection state
  logic        reached_r;      // level_reached_detect memory
  logic [KP_CNT_W-1:0] kp_cnt_r;
  logic        kp_err_r;       // persisted keypad error
  logic [NUM_SRC-1:0] src;     // all selectable sources

  // merge write data into an old word by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  stb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // current register images
  logic [31:0] sel_word;
  logic [31:0] det_word;
  logic [31:0] max_word;
  logic [31:0] st_word;
  always_comb begin
    sel_word = '0;
    sel_word[COL_SEL_LSB +: 5] = col_sel_r;
    sel_word[REL_SEL_LSB +: 5] = rel_sel_r;
    sel_word[FMODE_LSB +: 3]   = fmode_r;
    sel_word[KROUTE_LSB +: 2]  = kroute_r;
    sel_word[FAN_POL_BIT]      = fan_pol_r;
    sel_word[BRAKE_EN_BIT]     = brake_en_r;
    det_word = {bw_r, level_r};
    max_word = {16'h0000, maxf_r};
    st_word = '0;
    st_word[NUM_SRC-1:0]  = src;
    st_word[ST_COL_BIT]   = open_collector_out;
    st_word[ST_REL_BIT]   = relay_contact_out;
    st_word[ST_KERR_BIT]  = kp_err_r;
  end

  // write decode: both halves present and no response pending
  logic        wr_go;
  logic [31:0] wr_det;
  logic [31:0] wr_max;
  logic        det_ok;
  logic        wr_err;
  assign wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_det = merge(det_word, wdata_r, wstrb_r);
  assign wr_max = merge(max_word, wdata_r, wstrb_r);
  logic [31:0] wr_sel;         // select word after byte merge
  assign wr_sel = merge(sel_word, wdata_r, wstrb_r);
  // level and bandwidth capped at 400 Hz and the max frequency
  assign det_ok = (wr_det[LEVEL_LSB +: 16] <= FREQ_LIMIT)
               && (wr_det[LEVEL_LSB +: 16] <= maxf_r)
               && (wr_det[BW_LSB +: 16] <= FREQ_LIMIT)
               && (wr_det[BW_LSB +: 16] <= maxf_r); // R7
  always_comb begin
    unique case (awaddr_r)
      OFS_SELECT:  wr_err = 1'b0;
      OFS_DETECT:  wr_err = !det_ok;
      OFS_MAXFREQ: wr_err = wr_max[15:0] > FREQ_LIMIT;
      default:     wr_err = 1'b1;
    endcase
  end

  // write address channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_r     <= 1'b0;
      awaddr_r      <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r     <= 1'b1;
      awaddr_r      <= {s_axi_awaddr[3:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_have_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_r; // ready mirrors an empty latch
    end
  end

  // write data channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_have_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_have_r; // ready mirrors an empty latch
    end
  end

  // write response channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration register updates
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      col_sel_r  <= RST_COL_SEL;
      rel_sel_r  <= RST_REL_SEL;
      fmode_r    <= RST_FMODE;
      kroute_r   <= RST_KROUTE;
      fan_pol_r  <= 1'b0;
      brake_en_r <= 1'b0;
      level_r    <= RST_LEVEL; // R7
      bw_r       <= RST_BW; // R7
      maxf_r     <= RST_MAXFREQ;
    end else if (wr_go && !wr_err) begin
      unique case (awaddr_r)
        OFS_SELECT: begin
          col_sel_r  <= wr_sel[COL_SEL_LSB +: 5];
          rel_sel_r  <= wr_sel[REL_SEL_LSB +: 5];
          fmode_r    <= wr_sel[FMODE_LSB +: 3];
          kroute_r   <= wr_sel[KROUTE_LSB +: 2];
          fan_pol_r  <= wr_sel[FAN_POL_BIT];
          brake_en_r <= wr_sel[BRAKE_EN_BIT];
        end
        OFS_DETECT: begin
          level_r <= wr_det[LEVEL_LSB +: 16]; // R7
          bw_r    <= wr_det[BW_LSB +: 16]; // R7
        end
        OFS_MAXFREQ: begin
          maxf_r <= wr_max[15:0];
        end
        default: begin
          maxf_r <= maxf_r;
        end
      endcase
    end
  end

  // read channel, answer one cycle after address taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      unique case ({s_axi_araddr[3:2], 2'b00})
        OFS_SELECT:  s_axi_rdata <= sel_word;
        OFS_DETECT:  s_axi_rdata <= det_word;
        OFS_MAXFREQ: s_axi_rdata <= max_word;
        OFS_STATUS:  s_axi_rdata <= st_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid; // no answer pending
    end
  end

  // frequency comparisons, doubled to keep half bandwidth exact
  logic [16:0] d_cmd;          // |command - output|
  logic [16:0] d_lvl;          // |level - output|
  logic [17:0] out2_bw;        // 2*out + bw
  logic        match0;
  logic        win2;
  always_comb begin
    d_cmd = (core.cmd_freq >= core.out_freq)
          ? {1'b0, core.cmd_freq - core.out_freq}
          : {1'b0, core.out_freq - core.cmd_freq};
    d_lvl = (level_r >= core.out_freq)
          ? {1'b0, level_r - core.out_freq}
          : {1'b0, core.out_freq - level_r};
    out2_bw = {1'b0, core.out_freq, 1'b0} + {2'b00, bw_r};
  end
  assign match0 = {d_cmd, 1'b0} <= {2'b00, bw_r}; // R2
  assign win2   = {d_lvl, 1'b0} <= {2'b00, bw_r}; // R4

  // level reached memory, held at constant speed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reached_r <= 1'b0;
    end else if (core.accel) begin
      reached_r <= core.out_freq >= level_r; // R5
    end else if (core.decel) begin
      reached_r <= out2_bw > {1'b0, level_r, 1'b0}; // R5
    end
  end

  // fault source from mode bits
  logic fault_src;
  assign fault_src = (fmode_r[0] && core.uv_trip)
                  || (fmode_r[1] && core.other_trip)
                  || (fmode_r[2] && core.auto_restart); // R22 R19

  // source table
  always_comb begin
    src     = '0;
    src[0]  = match0; // R2
    src[1]  = (core.cmd_freq == level_r) && match0; // R3
    src[2]  = win2; // R4
    src[3]  = reached_r; // R5
    src[4]  = !reached_r; // R6
    src[5]  = core.overload_warning; // R8
    src[6]  = core.inv_overload;
    src[7]  = core.motor_stall;
    src[8]  = core.ov_trip; // R9
    src[9]  = core.uv_trip; // R10
    src[10] = core.heatsink_overheat; // R11
    src[11] = core.ref_lost || core.comm_lost; // R12
    src[12] = core.run_cmd && core.output_active; // R13
    src[13] = !core.run_cmd && !core.output_active; // R14
    src[14] = core.output_active && !core.accel && !core.decel; // R15
    src[15] = core.speed_search;
    src[16] = core.wait_run; // R16
    src[17] = fault_src; // R1
    src[18] = core.fan_fault && !fan_pol_r; // R17
    src[19] = core.brake_signal && brake_en_r; // R18
  end

  // keypad link error persistence counter
  always_ff @(posedge clk) begin
    if (sys_rst || !core.keypad_link_err) begin
      kp_cnt_r <= '0;
      kp_err_r <= 1'b0;
    end else if (kp_cnt_r >= KP_CNT_W'(KP_CYC - 1)) begin
      kp_err_r <= 1'b1; // R21
    end else begin
      kp_cnt_r <= kp_cnt_r + 1'b1;
    end
  end

  // output registers, codes above 19 select nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      open_collector_out <= 1'b0; // R23
      relay_contact_out  <= 1'b0; // R23
    end else begin
      open_collector_out <= ((col_sel_r < 5'(NUM_SRC)) && src[col_sel_r])
                         || (kroute_r[0] && kp_err_r); // R20 R23
      relay_contact_out  <= ((rel_sel_r < 5'(NUM_SRC)) && src[rel_sel_r])
                         || (kroute_r[1] && kp_err_r); // R20 R23
    end
  end

  // checks
  fault_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    (col_sel_r == SRC_FAULT) && !kroute_r[0] && $stable(col_sel_r)
    |=> open_collector_out == $past(fault_src)) // R1
    else $error("collector does not follow fault mode");
  match_band_a: assert property (@(posedge clk) disable iff (sys_rst)
    match0 |-> 2 * (core.cmd_freq > core.out_freq
      ? core.cmd_freq - core.out_freq : core.out_freq - core.cmd_freq)
      <= int'(bw_r)) // R2
    else $error("frequency match outside half bandwidth");
  level_match_a: assert property (@(posedge clk) disable iff (sys_rst)
    src[1] |-> src[0] && core.cmd_freq == level_r) // R3
    else $error("level match without base match");
  inv_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
    src[4] != src[3]) // R6
    else $error("inverted level output equals level output");
  accel_reach_a: assert property (@(posedge clk) disable iff (sys_rst)
    core.accel && core.out_freq >= level_r |=> src[3]) // R5
    else $error("level not reached during accel");
  hold_const_a: assert property (@(posedge clk) disable iff (sys_rst)
    !core.accel && !core.decel |=> $stable(reached_r)) // R5
    else $error("level memory moved at constant speed");
  det_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
    level_r <= FREQ_LIMIT && bw_r <= FREQ_LIMIT) // R7
    else $error("detect value above limit");
  uv_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
    fmode_r == 3'h2 && core.uv_trip && !core.other_trip
    |-> !fault_src) // R19
    else $error("undervoltage raised fault in mode 2");
  fan_policy_a: assert property (@(posedge clk) disable iff (sys_rst)
    fan_pol_r |-> !src[18]) // R17
    else $error("fan alarm with stop policy");
  kp_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    kp_err_r && kroute_r[1] |=> relay_contact_out) // R20
    else $error("keypad error not routed to relay");
  kp_persist_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(kp_err_r) |-> $past(core.keypad_link_err, 2)) // R21
    else $error("keypad error flagged too early");
  out_reset_a: assert property (@(posedge clk)
    sys_rst |=> !open_collector_out && !relay_contact_out) // R23
    else $error("outputs not cleared by reset");

  fault_seen_c: cover property (@(posedge clk) relay_contact_out
    && rel_sel_r == SRC_FAULT);
  decel_hyst_c: cover property (@(posedge clk) core.decel && src[3]
    && core.out_freq < level_r);
  kp_err_c: cover property (@(posedge clk) $rose(kp_err_r));
  wr_rej_c: cover property (@(posedge clk) wr_go && wr_err);

endmodule
`default_nettype wire

// ==== drive_core_model.sv ====
`default_nettype none
// stands in for the drive control core: holds frequencies and flags
// and presents them on the clock like the real core would
module drive_core_model
  import status_sel_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire core_status_t next_core,
  output core_status_t      core
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered so every change lands on a clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
  import status_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [4:0]   s;
    logic [2:0]   fm;
    logic [1:0]   cf;
    core_status_t c;
    logic         e;
  } row_t;
  logic         clk, sys_rst;
  core_status_t nc, core;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic         open_collector_out, relay_contact_out;
  int           errors, n_tests;
  row_t         rows[$];
  core_status_t c;

  drive_core_model drive_core_model_i (.clk(clk), .sys_rst(sys_rst),
    .next_core(nc), .core(core));
  status_output_selector #(.KP_CYC(20)) status_output_selector_i (
    .clk(clk), .sys_rst(sys_rst), .core(core),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .open_collector_out(open_collector_out),
    .relay_contact_out(relay_contact_out));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // verdict and end of run
  task automatic end_sim();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one write; readies sampled mid-cycle, stable until the next edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw, tb_;
    int   n;
    @(posedge clk); // one edge between transfers
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d; s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb_ = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb_) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 100) begin
      errors++;
      end_sim();
    end
  endtask

  // one read
  task automatic rdw(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tr;
    int   n;
    @(posedge clk); // one edge between transfers
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100) begin
      errors++;
      end_sim();
    end
  endtask

  // table row: both selects get the same code
  function automatic void add(logic [4:0] s, logic [2:0] fm,
                              logic [1:0] cf, core_status_t cc, logic e);
    rows.push_back('{s, fm, cf, cc, e});
  endfunction

  // select word: both codes, fault mode, keypad routing, policy bits
  function automatic logic [31:0] sw(logic [4:0] s, logic [2:0] fm,
                                     logic [1:0] kr, logic [1:0] cf);
    return {6'h00, cf, 2'h0, kr, 1'b0, fm, 3'h0, s, 3'h0, s};
  endfunction

  initial begin
    errors = 0; n_tests = 0; sys_rst = 1'b1; nc = '0;
    s_axi_awaddr = 4'h0; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // frequency rows use level 30.00 Hz, bandwidth 10.00 Hz
    c = '0; c.cmd_freq = 16'h0BB8; c.out_freq = 16'h09C4;
    add(5'h00, 3'h2, 2'h0, c, 1'b1);
    c.out_freq = 16'h09C3; add(5'h00, 3'h2, 2'h0, c, 1'b0);
    c.out_freq = 16'h0A28; add(5'h01, 3'h2, 2'h0, c, 1'b1);
    c.cmd_freq = 16'h0C1C; c.out_freq = 16'h0C1C;
    add(5'h01, 3'h2, 2'h0, c, 1'b0);
    c = '0; c.out_freq = 16'h0DAC; add(5'h02, 3'h2, 2'h0, c, 1'b1);
    c.out_freq = 16'h0DAD; add(5'h02, 3'h2, 2'h0, c, 1'b0);
    c = '0; c.accel = 1'b1; c.out_freq = 16'h0BB8;
    add(5'h03, 3'h2, 2'h0, c, 1'b1);
    add(5'h04, 3'h2, 2'h0, c, 1'b0);
    c.out_freq = 16'h0BB7; add(5'h03, 3'h2, 2'h0, c, 1'b0);
    c = '0; c.decel = 1'b1; c.out_freq = 16'h09C5;
    add(5'h03, 3'h2, 2'h0, c, 1'b1);
    c.out_freq = 16'h09C4; add(5'h03, 3'h2, 2'h0, c, 1'b0);
    add(5'h04, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.overload_warning = 1'b1; add(5'h05, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.ov_trip = 1'b1; add(5'h08, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.uv_trip = 1'b1; add(5'h09, 3'h2, 2'h0, c, 1'b1);
    add(5'h11, 3'h2, 2'h0, c, 1'b0);
    add(5'h11, 3'h1, 2'h0, c, 1'b1);
    c = '0; c.heatsink_overheat = 1'b1;
    add(5'h0A, 3'h2, 2'h0, c, 1'b1);
    c = '0; add(5'h0B, 3'h2, 2'h0, c, 1'b0);
    add(5'h0D, 3'h2, 2'h0, c, 1'b1);
    c.ref_lost = 1'b1; add(5'h0B, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.comm_lost = 1'b1; add(5'h0B, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.run_cmd = 1'b1; add(5'h0C, 3'h2, 2'h0, c, 1'b0);
    add(5'h0D, 3'h2, 2'h0, c, 1'b0);
    c.output_active = 1'b1; add(5'h0C, 3'h2, 2'h0, c, 1'b1);
    add(5'h0E, 3'h2, 2'h0, c, 1'b1);
    c.accel = 1'b1; add(5'h0E, 3'h2, 2'h0, c, 1'b0);
    c = '0; c.wait_run = 1'b1; add(5'h10, 3'h2, 2'h0, c, 1'b1);
    c = '0; c.other_trip = 1'b1; add(5'h11, 3'h2, 2'h0, c, 1'b1);
    add(5'h11, 3'h0, 2'h0, c, 1'b0);
    add(5'h14, 3'h2, 2'h0, c, 1'b0);
    c = '0; c.auto_restart = 1'b1; add(5'h11, 3'h4, 2'h0, c, 1'b1);
    c = '0; c.fan_fault = 1'b1; add(5'h12, 3'h2, 2'h0, c, 1'b1);
    add(5'h12, 3'h2, 2'h1, c, 1'b0);
    c = '0; c.brake_signal = 1'b1; add(5'h13, 3'h2, 2'h2, c, 1'b1);
    add(5'h13, 3'h2, 2'h0, c, 1'b0);
    foreach (rows[i]) begin
      wr(OFS_SELECT, sw(rows[i].s, rows[i].fm, 2'h0, rows[i].cf), rs);
      nc <= rows[i].c;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(open_collector_out, rows[i].e)
      `CHK(relay_contact_out, rows[i].e)
      @(posedge clk);
    end
    // limited writes of level, bandwidth and maximum frequency
    wr(OFS_DETECT, 32'h03E8_9C41, rs); `CHK(rs, RESP_SLVERR)
    rdw(OFS_DETECT, rd, rs); `CHK(rd, 32'h03E8_0BB8)
    wr(OFS_MAXFREQ, 32'h0000_4E20, rs); `CHK(rs, RESP_OKAY)
    wr(OFS_DETECT, 32'h03E8_61A8, rs); `CHK(rs, RESP_SLVERR)
    wr(OFS_DETECT, 32'h0190_4E20, rs); `CHK(rs, RESP_OKAY)
    rdw(OFS_DETECT, rd, rs); `CHK(rd, 32'h0190_4E20)
    wr(OFS_MAXFREQ, 32'h0000_9C41, rs); `CHK(rs, RESP_SLVERR)
    wr(OFS_STATUS, 32'h0000_0000, rs); `CHK(rs, RESP_SLVERR)
    // keypad error: shown only after persistence, per routing bit
    for (int r = 0; r < 4; r++) begin
      wr(OFS_SELECT, sw(5'h14, 3'h2, r[1:0], 2'h0), rs);
      c = '0; c.keypad_link_err = 1'b1; nc <= c;
      repeat (15) @(posedge clk);
      @(negedge clk);
      `CHK(open_collector_out, 1'b0)
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK(open_collector_out, r[0])
      `CHK(relay_contact_out, r[1])
      @(posedge clk);
      nc <= '0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(open_collector_out, 1'b0)
      @(posedge clk);
    end
    // reset in mid-run with an output asserted
    wr(OFS_SELECT, sw(5'h08, 3'h2, 2'h0, 2'h0), rs);
    c = '0; c.ov_trip = 1'b1; nc <= c;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(open_collector_out, 1'b1)
    @(posedge clk);
    rdw(OFS_STATUS, rd, rs);
    `CHK(rd, 32'h0300_2111)
    `CHK(rs, RESP_OKAY)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(open_collector_out, 1'b0)
    `CHK(relay_contact_out, 1'b0)
    @(posedge clk);
    sys_rst <= 1'b0;
    rdw(OFS_SELECT, rd, rs); `CHK(rd, 32'h0002_110C)
    rdw(OFS_DETECT, rd, rs); `CHK(rd, 32'h03E8_0BB8)
    rdw(OFS_MAXFREQ, rd, rs); `CHK(rd, 32'h0000_9C40)
    end_sim();
  end
endmodule
`default_nettype wire
